// >>> core/port0_soft_strap_defaults.sv
// port 0 soft-strap defaults loader with avalon-mm register slave
// assumes the eeprom loader and all pins are synchronous to i_clk
`timescale 1ns/1ps

module port0_soft_strap_defaults (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // avalon-mm slave
  input  wire logic [4:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  // eeprom loader
  input  wire logic        i_eeprom_valid,
  input  wire logic [4:0]  i_eeprom_straps,
  input  wire logic        i_eeprom_done,
  // port 0 link status
  input  wire logic [1:0]  i_port0_mode,
  input  wire logic        i_vaneg_failed,
  input  wire logic        i_vaneg_rate_100,
  input  wire logic        i_link_full_duplex,
  // port 0 outputs
  output logic             o_port0_rate_indicator_pin,
  output logic             o_port0_duplexity_indicator_pin,
  output logic             o_port0_rate_100,
  output logic             o_port0_backpressure_enable_bit,
  output logic             o_port0_rx_pause_enable_bit,
  output logic             o_port0_tx_pause_enable_bit,
  output logic      [1:0]  o_adv_pause,
  output logic             o_defaults_ready
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] partner_default(input logic [4:0] s);
    logic [15:0] v;
    v = port0_strap_pkg::REG16_RESET;
    v[port0_strap_pkg::LP_100X_FD] = s[port0_strap_pkg::STRAP_RATE] & s[port0_strap_pkg::STRAP_DUPLEX];
    v[port0_strap_pkg::LP_100X_HD] = s[port0_strap_pkg::STRAP_RATE] & ~s[port0_strap_pkg::STRAP_DUPLEX];
    v[port0_strap_pkg::LP_10T_FD]  = ~s[port0_strap_pkg::STRAP_RATE] & s[port0_strap_pkg::STRAP_DUPLEX];
    v[port0_strap_pkg::LP_10T_HD]  = ~s[port0_strap_pkg::STRAP_RATE] & ~s[port0_strap_pkg::STRAP_DUPLEX];
    v[port0_strap_pkg::LP_PAUSE]   = s[port0_strap_pkg::STRAP_FDPAUS];
    v[port0_strap_pkg::LP_ASYM]    = s[port0_strap_pkg::STRAP_FDPAUS];
    return v;
  endfunction

  function automatic logic polarity(input logic pol, input logic val);
    return pol ? val : ~val;
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] wd,
                                          input logic [1:0] be);
    return {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  port0_strap_pkg::load_state_t state_r;
  logic [4:0]  strap_r;
  logic [7:0]  wait_r;
  logic [15:0] partner_r;
  logic [15:0] advert_r;
  logic [15:0] pause_nxt;
  logic [2:0]  pause_r;
  logic        ack_r;
  logic        run;
  logic        req;
  logic        wr_hit;
  logic        rd_go;
  logic        rate_100;
  logic        mac_rmii;
  logic        mac_any;
  logic        live_r;

  assign run      = (state_r == port0_strap_pkg::ST_RUN);
  assign req      = i_avs_read | i_avs_write;
  assign wr_hit   = i_avs_write & ack_r;
  assign rd_go    = req & ~ack_r & run;
  assign mac_rmii = (i_port0_mode == port0_strap_pkg::MODE_RMII_MAC);
  assign mac_any  = mac_rmii | (i_port0_mode == port0_strap_pkg::MODE_MII_MAC);
  assign rate_100 = i_vaneg_failed ? strap_r[port0_strap_pkg::STRAP_RATE] : i_vaneg_rate_100;
  assign pause_nxt = merge16({13'h0000, pause_r}, i_avs_writedata[15:0], i_avs_byteenable[1:0]);

  // ----------------------------------------------------------------
  // load sequencer
  // ----------------------------------------------------------------
  // a silent loader must not hang the port: after the wait, defaults apply
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_r <= port0_strap_pkg::ST_LOAD;
      wait_r  <= 8'h00;
    end else begin
      case (state_r)
        port0_strap_pkg::ST_LOAD: begin
          wait_r <= wait_r + 8'h01;
          if (i_eeprom_done || wait_r == port0_strap_pkg::LOAD_WAIT_CYC - 8'h01) begin
            state_r <= port0_strap_pkg::ST_APPLY;
          end
        end
        port0_strap_pkg::ST_APPLY: state_r <= port0_strap_pkg::ST_RUN;
        port0_strap_pkg::ST_RUN:   state_r <= port0_strap_pkg::ST_RUN;
        default:                   state_r <= port0_strap_pkg::ST_LOAD;
      endcase
    end
  end

  // straps are frozen once applied; the loader only acts while loading
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      strap_r <= port0_strap_pkg::STRAP_RESET;
    end else if (state_r == port0_strap_pkg::ST_LOAD && i_eeprom_valid) begin
      strap_r <= i_eeprom_straps;
    end
  end

  // ----------------------------------------------------------------
  // target registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      partner_r <= port0_strap_pkg::REG16_RESET;
    end else if (state_r == port0_strap_pkg::ST_APPLY) begin
      partner_r <= partner_default(strap_r);
    end else if (wr_hit && i_avs_address == port0_strap_pkg::ADDR_PARTNER) begin
      partner_r <= merge16(partner_r, i_avs_writedata[15:0], i_avs_byteenable[1:0]);
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      advert_r <= port0_strap_pkg::REG16_RESET;
    end else if (state_r == port0_strap_pkg::ST_APPLY) begin
      advert_r <= port0_strap_pkg::REG16_RESET;
      advert_r[port0_strap_pkg::ADV_SYM]  <= strap_r[port0_strap_pkg::STRAP_MANPAU];
      advert_r[port0_strap_pkg::ADV_ASYM] <= strap_r[port0_strap_pkg::STRAP_MANPAU];
    end else if (wr_hit && i_avs_address == port0_strap_pkg::ADDR_ADVERT) begin
      advert_r <= merge16(advert_r, i_avs_writedata[15:0], i_avs_byteenable[1:0]);
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      pause_r <= port0_strap_pkg::PAUSE_RESET;
    end else if (state_r == port0_strap_pkg::ST_APPLY) begin
      pause_r[port0_strap_pkg::PC_BACKP] <= strap_r[port0_strap_pkg::STRAP_BACKP];
      pause_r[port0_strap_pkg::PC_RX]    <= strap_r[port0_strap_pkg::STRAP_FDPAUS];
      pause_r[port0_strap_pkg::PC_TX]    <= strap_r[port0_strap_pkg::STRAP_FDPAUS];
    end else if (wr_hit && i_avs_address == port0_strap_pkg::ADDR_PAUSE) begin
      pause_r <= pause_nxt[2:0];
    end
  end

  // ----------------------------------------------------------------
  // avalon-mm slave
  // ----------------------------------------------------------------
  // one wait state per access; the bus stalls until the defaults are applied
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= rd_go;
    end
  end

  assign o_avs_waitrequest = ~ack_r;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_avs_readdata <= 32'h00000000;
    end else if (rd_go) begin
      case (i_avs_address)
        port0_strap_pkg::ADDR_STRAP:   o_avs_readdata <= {27'h0000000, strap_r};
        port0_strap_pkg::ADDR_PARTNER: o_avs_readdata <= {16'h0000, partner_r};
        port0_strap_pkg::ADDR_ADVERT:  o_avs_readdata <= {16'h0000, advert_r};
        port0_strap_pkg::ADDR_PAUSE:   o_avs_readdata <= {29'h00000000, pause_r};
        port0_strap_pkg::ADDR_STATUS:  o_avs_readdata <= {29'h00000000, i_vaneg_failed, rate_100, run};
        default:                       o_avs_readdata <= 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // port 0 outputs
  // ----------------------------------------------------------------
  // pins are idle low outside the mac modes that own them
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_port0_rate_indicator_pin      <= 1'b0;
      o_port0_duplexity_indicator_pin <= 1'b0;
      o_port0_rate_100                <= 1'b0;
    end else begin
      o_port0_rate_100 <= rate_100;
      o_port0_rate_indicator_pin <= mac_rmii & polarity(strap_r[port0_strap_pkg::STRAP_RATE], rate_100);
      o_port0_duplexity_indicator_pin <= mac_any &
        polarity(strap_r[port0_strap_pkg::STRAP_DUPLEX], i_link_full_duplex);
    end
  end

  assign o_port0_backpressure_enable_bit = pause_r[port0_strap_pkg::PC_BACKP];
  assign o_port0_rx_pause_enable_bit     = pause_r[port0_strap_pkg::PC_RX];
  assign o_port0_tx_pause_enable_bit     = pause_r[port0_strap_pkg::PC_TX];
  assign o_adv_pause = {advert_r[port0_strap_pkg::ADV_ASYM], advert_r[port0_strap_pkg::ADV_SYM]};
  assign o_defaults_ready = run;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  // low on the first edge out of reset, so pin checks never judge reset values
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      live_r <= 1'b0;
    end else begin
      live_r <= 1'b1;
    end
  end

  property p_partner_rate;
    @(posedge i_clk) disable iff (!i_rst_n)
    state_r == port0_strap_pkg::ST_APPLY |=>
      partner_r[port0_strap_pkg::LP_100X_HD] == ($past(strap_r[0]) & ~$past(strap_r[1]));
  endproperty
  a_partner_rate: assert property (p_partner_rate) else $error("rate bits not from strap");

  property p_fallback;
    @(posedge i_clk) disable iff (!i_rst_n || !live_r)
    i_vaneg_failed |=> o_port0_rate_100 == $past(strap_r[port0_strap_pkg::STRAP_RATE]);
  endproperty
  a_fallback: assert property (p_fallback) else $error("fallback speed not strap");

  property p_rate_pin;
    @(posedge i_clk) disable iff (!i_rst_n || !live_r)
    mac_rmii ##1 1'b1 |-> o_port0_rate_indicator_pin == ($past(strap_r[0]) ~^ $past(rate_100));
  endproperty
  a_rate_pin: assert property (p_rate_pin) else $error("rate pin polarity wrong");

  property p_strap_frozen;
    @(posedge i_clk) disable iff (!i_rst_n)
    run |=> $stable(strap_r) && o_defaults_ready;
  endproperty
  a_strap_frozen: assert property (p_strap_frozen) else $error("shared strap bits moved");

  property p_partner_duplex;
    @(posedge i_clk) disable iff (!i_rst_n)
    state_r == port0_strap_pkg::ST_APPLY |=>
      partner_r[port0_strap_pkg::LP_10T_FD] == (~$past(strap_r[0]) & $past(strap_r[1]));
  endproperty
  a_partner_duplex: assert property (p_partner_duplex) else $error("duplex bits not from strap");

  property p_duplex_pin;
    @(posedge i_clk) disable iff (!i_rst_n || !live_r)
    mac_any |=> o_port0_duplexity_indicator_pin == ($past(strap_r[1]) ~^ $past(i_link_full_duplex));
  endproperty
  a_duplex_pin: assert property (p_duplex_pin) else $error("duplex pin polarity wrong");

  property p_backp;
    @(posedge i_clk) disable iff (!i_rst_n)
    state_r == port0_strap_pkg::ST_APPLY |=> o_port0_backpressure_enable_bit == $past(strap_r[2]);
  endproperty
  a_backp: assert property (p_backp) else $error("backpressure default wrong");

  property p_fd_pause;
    @(posedge i_clk) disable iff (!i_rst_n)
    state_r == port0_strap_pkg::ST_APPLY |=>
      o_port0_rx_pause_enable_bit == $past(strap_r[3]) && o_port0_tx_pause_enable_bit == $past(strap_r[3]);
  endproperty
  a_fd_pause: assert property (p_fd_pause) else $error("pause enables default wrong");

  property p_lp_pause;
    @(posedge i_clk) disable iff (!i_rst_n)
    state_r == port0_strap_pkg::ST_APPLY |=>
      partner_r[port0_strap_pkg::LP_PAUSE] == $past(strap_r[3]) && partner_r[port0_strap_pkg::LP_ASYM] == $past(strap_r[3]);
  endproperty
  a_lp_pause: assert property (p_lp_pause) else $error("partner pause default wrong");

  property p_adv;
    @(posedge i_clk) disable iff (!i_rst_n)
    state_r == port0_strap_pkg::ST_APPLY |=> o_adv_pause == {2{$past(strap_r[4])}};
  endproperty
  a_adv: assert property (p_adv) else $error("advert pause default wrong");

  property p_loader;
    @(posedge i_clk) disable iff (!i_rst_n)
    state_r == port0_strap_pkg::ST_LOAD && i_eeprom_valid |=> strap_r == $past(i_eeprom_straps);
  endproperty
  a_loader: assert property (p_loader) else $error("loader value not taken");

  property p_write_wins;
    @(posedge i_clk) disable iff (!i_rst_n)
    wr_hit && i_avs_address == port0_strap_pkg::ADDR_PAUSE && i_avs_byteenable[0] |=>
      pause_r == $past(i_avs_writedata[2:0]) ##1 !run || pause_r == $past(pause_r) || ack_r;
  endproperty
  a_write_wins: assert property (p_write_wins) else $error("software write lost");

  property p_answer;
    @(posedge i_clk) disable iff (!i_rst_n)
    run && req |-> ##[0:1] !o_avs_waitrequest;
  endproperty
  a_answer: assert property (p_answer) else $error("bus answer late");

  property p_partner_onehot;
    @(posedge i_clk) disable iff (!i_rst_n)
    state_r == port0_strap_pkg::ST_APPLY |=>
      $onehot({partner_r[port0_strap_pkg::LP_100X_FD], partner_r[port0_strap_pkg::LP_100X_HD],
               partner_r[port0_strap_pkg::LP_10T_FD], partner_r[port0_strap_pkg::LP_10T_HD]});
  endproperty
  a_partner_onehot: assert property (p_partner_onehot) else $error("ability bits not one-hot");

  property p_partner_full;
    @(posedge i_clk) disable iff (!i_rst_n)
    state_r == port0_strap_pkg::ST_APPLY |=>
      partner_r[port0_strap_pkg::LP_100X_FD] == ($past(strap_r[0]) & $past(strap_r[1]));
  endproperty
  a_partner_full: assert property (p_partner_full) else $error("full duplex bit not from strap");

  property p_load_bound;
    @(posedge i_clk) disable iff (!i_rst_n)
    state_r == port0_strap_pkg::ST_LOAD |-> wait_r < port0_strap_pkg::LOAD_WAIT_CYC;
  endproperty
  a_load_bound: assert property (p_load_bound) else $error("load phase overran its wait");

  property p_apply_once;
    @(posedge i_clk) disable iff (!i_rst_n)
    state_r == port0_strap_pkg::ST_APPLY |=> run;
  endproperty
  a_apply_once: assert property (p_apply_once) else $error("defaults applied more than once");

  property p_rate_pin_idle;
    @(posedge i_clk) disable iff (!i_rst_n)
    !mac_rmii |=> !o_port0_rate_indicator_pin;
  endproperty
  a_rate_pin_idle: assert property (p_rate_pin_idle) else $error("rate pin driven outside rmii mac");

  property p_duplex_pin_idle;
    @(posedge i_clk) disable iff (!i_rst_n)
    !mac_any |=> !o_port0_duplexity_indicator_pin;
  endproperty
  a_duplex_pin_idle: assert property (p_duplex_pin_idle) else $error("duplex pin driven outside mac");

endmodule // port0_soft_strap_defaults

// >>> inc/port0_strap_pkg.sv
// port 0 soft-strap defaults: offsets, field positions, reset values
// assumes a 32-bit avalon-mm slave with byte addresses and 16 live bits
package port0_strap_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [4:0] ADDR_STRAP   = 5'h00;
  localparam logic [4:0] ADDR_PARTNER = 5'h04;
  localparam logic [4:0] ADDR_ADVERT  = 5'h08;
  localparam logic [4:0] ADDR_PAUSE   = 5'h0C;
  localparam logic [4:0] ADDR_STATUS  = 5'h10;

  // ----------------------------------------------------------------
  // strap word: speed/speed-polarity share bit 0, duplex pair bit 1
  // ----------------------------------------------------------------
  localparam int STRAP_RATE   = 0;
  localparam int STRAP_DUPLEX = 1;
  localparam int STRAP_BACKP  = 2;
  localparam int STRAP_FDPAUS = 3;
  localparam int STRAP_MANPAU = 4;
  localparam logic [4:0] STRAP_RESET = 5'h0F;

  // ----------------------------------------------------------------
  // virtual_phy_partner_ability and virtual_phy_advertisement fields
  // ----------------------------------------------------------------
  localparam int LP_10T_HD   = 5;
  localparam int LP_10T_FD   = 6;
  localparam int LP_100X_HD  = 7;
  localparam int LP_100X_FD  = 8;
  localparam int LP_PAUSE    = 10;
  localparam int LP_ASYM     = 11;
  localparam int ADV_SYM     = 10;
  localparam int ADV_ASYM    = 11;
  localparam logic [15:0] REG16_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // port0_manual_pause_control fields
  // ----------------------------------------------------------------
  localparam int PC_BACKP = 0;
  localparam int PC_RX    = 1;
  localparam int PC_TX    = 2;
  localparam logic [2:0] PAUSE_RESET = 3'h0;

  // ----------------------------------------------------------------
  // port 0 modes and loader wait
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_MII_MAC  = 2'h0;
  localparam logic [1:0] MODE_RMII_MAC = 2'h2;
  localparam logic [1:0] MODE_RMII_PHY = 2'h3;
  localparam logic [7:0] LOAD_WAIT_CYC = 8'h40;

  typedef enum logic [1:0] {ST_LOAD, ST_APPLY, ST_RUN} load_state_t;

endpackage

// >>> verif/eeprom_loader_model.sv
// behavioural eeprom loader feeding soft-strap replacement values
// assumes bench sets i_use, i_val and i_dly before reset is released
`timescale 1ns/1ps

module eeprom_loader_model (
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  // bench control
  input  wire logic       i_use,
  input  wire logic [4:0] i_val,
  input  wire logic [7:0] i_dly,
  // loader side
  output logic            o_valid,
  output logic [4:0]      o_straps,
  output logic            o_done
);
  logic [4:0] held;
  logic       tick = 1'b0;

  // released data line toggles every cycle between the inverse of the held value and the held value
  assign o_straps = o_valid ? held : (~held ^ {5{tick}});

  always @(posedge i_clk) tick <= ~tick;

  initial begin
    o_valid = 1'b0;
    o_done  = 1'b0;
    held    = 5'h00;
    forever begin
      @(posedge i_rst_n);
      if (i_use) begin
        repeat (i_dly) @(posedge i_clk);
        o_valid <= 1'b1;
        held    <= ~i_val;
        @(posedge i_clk);
        held    <= i_val;
        o_done  <= 1'b1;
        @(posedge i_clk);
        o_valid <= 1'b0;
        o_done  <= 1'b0;
      end
    end
  end
endmodule // eeprom_loader_model

// >>> verif/port0_soft_strap_defaults_tb.sv
// self-checking bench for the port 0 soft-strap defaults block
// assumes the package offsets and field positions of the design
`timescale 1ns/1ps

module port0_soft_strap_defaults_tb;
  logic        i_clk = 1'b0;
  logic        i_rst_n = 1'b0;
  logic [4:0]  adr = 5'h00;
  logic        rd = 1'b0, wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [3:0]  be = 4'hF;
  logic [31:0] o_avs_readdata;
  logic        o_avs_waitrequest, ee_valid, ee_done, use_ee = 1'b0;
  logic [4:0]  ee_straps, ee_val = 5'h0F;
  logic [7:0]  ee_dly = 8'h00;
  logic [1:0]  mode = 2'h0;
  logic        fail = 1'b0, r100 = 1'b0, fd = 1'b0;
  logic        rate_pin, dup_pin, rate_100, bp_bit, rx_bit, tx_bit, ready;
  logic [1:0]  adv;
  int          mismatches = 0, n_tests = 0, cycles = 0;

  initial forever #25 i_clk = ~i_clk;

  port0_soft_strap_defaults uut (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wd), .i_avs_byteenable(be), .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest), .i_eeprom_valid(ee_valid), .i_eeprom_straps(ee_straps),
    .i_eeprom_done(ee_done), .i_port0_mode(mode), .i_vaneg_failed(fail), .i_vaneg_rate_100(r100),
    .i_link_full_duplex(fd), .o_port0_rate_indicator_pin(rate_pin), .o_port0_duplexity_indicator_pin(dup_pin),
    .o_port0_rate_100(rate_100), .o_port0_backpressure_enable_bit(bp_bit), .o_port0_rx_pause_enable_bit(rx_bit),
    .o_port0_tx_pause_enable_bit(tx_bit), .o_adv_pause(adv), .o_defaults_ready(ready));

  eeprom_loader_model ldr (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_use(use_ee), .i_val(ee_val), .i_dly(ee_dly),
    .o_valid(ee_valid), .o_straps(ee_straps), .o_done(ee_done));

  // ----------------------------------------------------------------
  // checking and closing
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    if (mismatches == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // whole run needs about 8 x 150 cycles; ceiling leaves wide margin
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      stop_test();
    end
  end

  // ----------------------------------------------------------------
  // avalon-mm master and expectations
  // ----------------------------------------------------------------
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge i_clk);
    adr <= a;
    rd  <= ~w;
    wr  <= w;
    wd  <= d;
    // waitrequest and read data are taken at the rising edge, before it updates them
    do begin
      @(posedge i_clk);
      n++;
    end while (o_avs_waitrequest !== 1'b0 && n < 300);
    q = o_avs_readdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 300) check(32'h1, 32'h0);
  endtask

  function automatic logic [31:0] exp_partner(input logic [4:0] s);
    logic [31:0] r;
    r = 32'h0;
    r[port0_strap_pkg::LP_100X_FD] = s[0] & s[1];
    r[port0_strap_pkg::LP_100X_HD] = s[0] & ~s[1];
    r[port0_strap_pkg::LP_10T_FD]  = ~s[0] & s[1];
    r[port0_strap_pkg::LP_10T_HD]  = ~s[0] & ~s[1];
    r[port0_strap_pkg::LP_PAUSE]   = s[3];
    r[port0_strap_pkg::LP_ASYM]    = s[3];
    return r;
  endfunction

  function automatic logic [31:0] exp_advert(input logic [4:0] s);
    logic [31:0] r;
    r = 32'h0;
    r[port0_strap_pkg::ADV_SYM]  = s[4];
    r[port0_strap_pkg::ADV_ASYM] = s[4];
    return r;
  endfunction

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [4:0]  s;
    logic [31:0] q, v, ep;
    logic        e100;
    void'($urandom(32'hEA44));
    for (int it = 0; it < 8; it++) begin
      s = (it == 1) ? 5'h00 : (it == 2) ? 5'h1F : 5'($urandom);
      use_ee <= (it != 0);
      ee_val <= s;
      ee_dly <= 8'($urandom % 20);
      if (it == 0) s = port0_strap_pkg::STRAP_RESET;
      i_rst_n <= 1'b0;
      repeat (2) @(posedge i_clk);
      i_rst_n <= 1'b1;
      bus(1'b0, port0_strap_pkg::ADDR_STRAP, 32'h0, q);
      check(q, {27'h0, s});
      check({31'h0, ready}, 32'h1);
      bus(1'b0, port0_strap_pkg::ADDR_PARTNER, 32'h0, q);
      check(q, exp_partner(s));
      bus(1'b0, port0_strap_pkg::ADDR_ADVERT, 32'h0, q);
      check(q, exp_advert(s));
      check({30'h0, adv}, {30'h0, s[4], s[4]});
      bus(1'b0, port0_strap_pkg::ADDR_PAUSE, 32'h0, q);
      check(q, {29'h0, s[3], s[3], s[2]});
      check({29'h0, tx_bit, rx_bit, bp_bit}, {29'h0, s[3], s[3], s[2]});
      for (int k = 0; k < 6; k++) begin
        @(posedge i_clk);
        mode <= (k % 3 == 0) ? port0_strap_pkg::MODE_MII_MAC :
                (k % 3 == 1) ? port0_strap_pkg::MODE_RMII_MAC : port0_strap_pkg::MODE_RMII_PHY;
        fail <= 1'($urandom);
        r100 <= 1'($urandom);
        fd   <= 1'($urandom);
        repeat (3) @(negedge i_clk);
        e100 = fail ? s[0] : r100;
        check({31'h0, rate_100}, {31'h0, e100});
        check({31'h0, rate_pin}, {31'h0, (mode == 2'h2) & (s[0] ? e100 : ~e100)});
        check({31'h0, dup_pin}, {31'h0, (mode != 2'h3) & (s[1] ? fd : ~fd)});
        bus(1'b0, port0_strap_pkg::ADDR_STATUS, 32'h0, q);
        check(q, {29'h0, fail, e100, 1'b1});
      end
      v = $urandom;
      bus(1'b1, port0_strap_pkg::ADDR_PAUSE, v, q);
      bus(1'b0, port0_strap_pkg::ADDR_PAUSE, 32'h0, q);
      check(q, {29'h0, v[2:0]});
      check({29'h0, tx_bit, rx_bit, bp_bit}, {29'h0, v[2:0]});
      be <= 4'h1;
      bus(1'b1, port0_strap_pkg::ADDR_PARTNER, v, q);
      be <= 4'hF;
      bus(1'b0, port0_strap_pkg::ADDR_PARTNER, 32'h0, q);
      ep = exp_partner(s);
      check(q, {16'h0, ep[15:8], v[7:0]});
      bus(1'b1, port0_strap_pkg::ADDR_ADVERT, v, q);
      @(negedge i_clk);
      check({30'h0, adv}, {30'h0, v[port0_strap_pkg::ADV_ASYM], v[port0_strap_pkg::ADV_SYM]});
      bus(1'b1, port0_strap_pkg::ADDR_STRAP, v, q);
      bus(1'b0, port0_strap_pkg::ADDR_STRAP, 32'h0, q);
      check(q, {27'h0, s});
      bus(1'b0, 5'h14, 32'h0, q);
      check(q, 32'h0);
    end
    stop_test();
  end
endmodule // port0_soft_strap_defaults_tb
